// file: backlight_brightness_ctrl_consts.svh
/*
 * Register indices, field positions, reset values and timing figures of the
 * backlight and brightness control register bank.
 * Assumes nothing; included by the register bank and the PWM generator modules.
 */
`ifndef BACKLIGHT_BRIGHTNESS_CTRL_CONSTS_SVH
`define BACKLIGHT_BRIGHTNESS_CTRL_CONSTS_SVH

// register indices; the byte address is four times the index
`define IDX_CTRL_ONE        8'hE9
`define IDX_CTRL_TWO        8'hEA
`define IDX_STATUS          8'hEB

// brightness_control_one fields
`define C1_TARGET_MSB       15
`define C1_TARGET_LSB       8
`define C1_RESERVED_BIT     7
`define C1_GAMMA_BIT        6
`define C1_BACKLIGHT_BIT    5
`define C1_DIMMING_BIT      4
`define C1_BLOCK_BIT        3
`define C1_MODE_MSB         2
`define C1_MODE_LSB         1
`define C1_ENABLE_BIT       0

// brightness_control_two fields
`define C2_BACKLIGHT_PWM_PRESCALE_MSB       15
`define C2_BACKLIGHT_PWM_PRESCALE_LSB       12
`define C2_ITER_PS_MSB      11
`define C2_ITER_PS_LSB      8
`define C2_MIN_MSB          7
`define C2_MIN_LSB          0

// status fields
`define ST_LINE_BIT         8

`define CTRL_ONE_RESET      16'h0000
`define CTRL_TWO_RESET      16'h0000

// iteration period is 2^(ITER_BASE_SHIFT + prescale) clock cycles
`define ITER_BASE_SHIFT     5'h0A
`define ITER_CNT_W          26
`define PWM_PRE_W           16
`define CLK_PERIOD_NS       100

`endif

// file: backlight_brightness_ctrl_pkg.sv
/*
 * Types of the backlight and brightness control register bank.
 * Assumes the constants header sits in the same folder.
 */
`default_nettype none

package backlight_brightness_ctrl_pkg;

    typedef enum logic [1:0] {
        MODE_OFF          = 2'b00,
        MODE_CONSERVATION = 2'b01,
        MODE_NORMAL       = 2'b10,
        MODE_AGGRESSIVE   = 2'b11
    } preservation_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_WRITE   = 2'b01,
        BUS_READ    = 2'b10,
        BUS_READ_OK = 2'b11
    } bus_state_e;

    typedef struct packed {
        logic [7:0]         target_brightness;
        logic               reserved;
        logic               gamma_eighteen_select;
        logic               backlight_on;
        logic               display_dimming;
        logic               brightness_block_on;
        preservation_mode_e preservation_mode;
        logic               adaptive_backlight_enable;
    } ctrl_one_s;

    typedef struct packed {
        logic [3:0] backlight_pwm_prescale;
        logic [3:0] iteration_rate_prescale;
        logic [7:0] minimum_brightness;
    } ctrl_two_s;

endpackage : backlight_brightness_ctrl_pkg

`default_nettype wire

// file: backlight_brightness_ctrl_regs.sv
/*
 * Backlight and brightness control register bank with its AHB-Lite slave,
 * the applied brightness calculation and the backlight PWM output.
 * Assumes a single AHB-Lite master, word transfers, and a pixel clock on
 * clk_i; the interface select pin arrives asynchronously.
 */
// Function
// - upper byte of control one holds the eight-bit target brightness setting.
// - bit 6 of control one selects the gamma eighteen option.
// - backlight enable bit 5 low forces the backlight line fully off.
// - bit 4 switches display dimming on or off.
// - bit 3 switches the brightness control block on or off.
// - mode field bits 2-1: off, conservation, normal, aggressive.
// - bit 0 enables the adaptive backlight feature.
// - adaptive enable counts only while interface select pin is low.
// - control two bits 15-12 set the backlight PWM frequency prescale.
// - control two bits 11-8 set the brightness iteration rate prescale.
// - adaptive brightness goal never drops below the minimum brightness byte.
// - backlight line is a PWM output, its level readable in status.
`timescale 1ns/1ns
`default_nettype none
`include "backlight_brightness_ctrl_consts.svh"

module backlight_brightness_ctrl_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // interface select pin, asynchronous
    input  wire logic        interface_select_i,
    // block outputs
    output logic             backlight_output_line_o,
    output logic      [7:0]  brightness_level_o,
    output logic             gamma_eighteen_select_o,
    output logic             display_dimming_o,
    output logic             brightness_block_on_o,
    output logic      [1:0]  preservation_mode_o,
    output logic             adaptive_active_o
);

    backlight_brightness_ctrl_pkg::ctrl_one_s  ctrl_one_ff;
    backlight_brightness_ctrl_pkg::ctrl_two_s  ctrl_two_ff;
    backlight_brightness_ctrl_pkg::bus_state_e bus_state_ff;
    backlight_brightness_ctrl_pkg::bus_state_e nxt_bus_state;

    logic [9:0]             addr_ff;
    logic [31:0]            hrdata_ff;
    logic                   hreadyout_ff;
    logic                   sel_meta_ff;
    logic                   sel_sync_ff;
    logic [`ITER_CNT_W-1:0] iter_cnt_ff;
    logic [7:0]             level_ff;
    logic                   adaptive_ff;

    // bus decode
    wire        take;
    wire        hit_one;
    wire        hit_two;
    wire        hit_status;
    wire        wr_one;
    wire        wr_two;
    wire [31:0] rd_mux;
    wire [15:0] wr_one_val;
    wire        line_level;

    // a read waits one cycle so it always sees a write in its data phase
    assign take = hsel_i && htrans_i[1] && hready_i && (bus_state_ff != backlight_brightness_ctrl_pkg::BUS_READ);

    assign hit_one    = (addr_ff == {2'b00, `IDX_CTRL_ONE});
    assign hit_two    = (addr_ff == {2'b00, `IDX_CTRL_TWO});
    assign hit_status = (addr_ff == {2'b00, `IDX_STATUS});
    assign wr_one     = (bus_state_ff == backlight_brightness_ctrl_pkg::BUS_WRITE) && hit_one;
    assign wr_two     = (bus_state_ff == backlight_brightness_ctrl_pkg::BUS_WRITE) && hit_two;

    // reserved bit never stores a one
    assign wr_one_val = hwdata_i[15:0] & ~(16'h0001 << `C1_RESERVED_BIT);

    // unmapped addresses read zero, bits above 15 read zero
    assign rd_mux = hit_one    ? {16'h0000, ctrl_one_ff} :
                    hit_two    ? {16'h0000, ctrl_two_ff} :
                    hit_status ? {23'h000000, line_level, level_ff} :
                    32'h00000000;

    always_comb begin
        nxt_bus_state = bus_state_ff;
        case (bus_state_ff)
            backlight_brightness_ctrl_pkg::BUS_READ: begin
                nxt_bus_state = backlight_brightness_ctrl_pkg::BUS_READ_OK;
            end
            backlight_brightness_ctrl_pkg::BUS_IDLE,
            backlight_brightness_ctrl_pkg::BUS_WRITE,
            backlight_brightness_ctrl_pkg::BUS_READ_OK: begin
                if (take && hwrite_i) begin
                    nxt_bus_state = backlight_brightness_ctrl_pkg::BUS_WRITE;
                end else if (take) begin
                    nxt_bus_state = backlight_brightness_ctrl_pkg::BUS_READ;
                end else begin
                    nxt_bus_state = backlight_brightness_ctrl_pkg::BUS_IDLE;
                end
            end
            default: begin
                nxt_bus_state = backlight_brightness_ctrl_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_state_ff <= backlight_brightness_ctrl_pkg::BUS_IDLE;
            addr_ff      <= 10'h000;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h00000000;
        end else begin
            bus_state_ff <= nxt_bus_state;
            addr_ff      <= take ? haddr_i[11:2] : addr_ff;
            hreadyout_ff <= !(take && !hwrite_i);
            hrdata_ff    <= (bus_state_ff == backlight_brightness_ctrl_pkg::BUS_READ) ? rd_mux : hrdata_ff;
        end
    end

    // register file
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_one_ff <= `CTRL_ONE_RESET;
            ctrl_two_ff <= `CTRL_TWO_RESET;
        end else begin
            if (wr_one) begin
                ctrl_one_ff <= wr_one_val;
            end
            if (wr_two) begin
                ctrl_two_ff <= hwdata_i[15:0];
            end
        end
    end

    // interface select pin synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_meta_ff <= 1'b0;
            sel_sync_ff <= 1'b0;
        end else begin
            sel_meta_ff <= interface_select_i;
            sel_sync_ff <= sel_meta_ff;
        end
    end

    // brightness calculation
    wire [`ITER_CNT_W-1:0] iter_limit;
    wire                   iter_tick;
    wire                   adaptive_on;
    wire [7:0]             target;
    wire [7:0]             floor_level;
    wire [7:0]             reduced;
    wire [7:0]             clamped;
    wire [7:0]             goal;
    wire [7:0]             stepped;

    // one calculation per 2^(base + prescale) pixel clocks
    assign iter_limit = (`ITER_CNT_W'(1) << (`ITER_BASE_SHIFT + {1'b0, ctrl_two_ff.iteration_rate_prescale}))
                        - `ITER_CNT_W'(1);
    assign iter_tick  = (iter_cnt_ff >= iter_limit);

    assign adaptive_on = ctrl_one_ff.adaptive_backlight_enable && !sel_sync_ff;

    assign target      = ctrl_one_ff.target_brightness;
    assign floor_level = ctrl_two_ff.minimum_brightness;

    // preservation mode trims the target, harder for moving images
    assign reduced =
        (ctrl_one_ff.preservation_mode == backlight_brightness_ctrl_pkg::MODE_CONSERVATION) ? target - (target >> 3) :
        (ctrl_one_ff.preservation_mode == backlight_brightness_ctrl_pkg::MODE_NORMAL)       ? target - (target >> 2) :
        (ctrl_one_ff.preservation_mode == backlight_brightness_ctrl_pkg::MODE_AGGRESSIVE)   ? target - (target >> 1) :
        target;

    assign clamped = (reduced < floor_level) ? floor_level : reduced;
    assign goal    = adaptive_on ? clamped : target;

    // dimming walks one code per iteration instead of jumping
    assign stepped = (level_ff < goal) ? level_ff + 8'h01 :
                     (level_ff > goal) ? level_ff - 8'h01 :
                     level_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            iter_cnt_ff <= '0;
            level_ff    <= 8'h00;
            adaptive_ff <= 1'b0;
        end else begin
            iter_cnt_ff <= iter_tick ? '0 : iter_cnt_ff + `ITER_CNT_W'(1);
            adaptive_ff <= adaptive_on && ctrl_one_ff.brightness_block_on;
            if (!ctrl_one_ff.brightness_block_on) begin
                level_ff <= target;
            end else if (iter_tick) begin
                level_ff <= ctrl_one_ff.display_dimming ? stepped : goal;
            end
        end
    end

    // a floor raised mid-ramp could leave the level below it for a while;
    // the gap is closed by the next iteration, or one code per iteration while dimming is on, which is accepted
    backlight_pwm_gen u_pwm (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (ctrl_one_ff.backlight_on),
        .prescale_i (ctrl_two_ff.backlight_pwm_prescale),
        .duty_i     (level_ff),
        .pwm_o      (line_level)
    );

    assign hrdata_o                = hrdata_ff;
    assign hreadyout_o             = hreadyout_ff;
    assign hresp_o                 = 1'b0;
    assign backlight_output_line_o = line_level;
    assign brightness_level_o      = level_ff;
    assign gamma_eighteen_select_o = ctrl_one_ff.gamma_eighteen_select;
    assign display_dimming_o       = ctrl_one_ff.display_dimming;
    assign brightness_block_on_o   = ctrl_one_ff.brightness_block_on;
    assign preservation_mode_o     = ctrl_one_ff.preservation_mode;
    assign adaptive_active_o       = adaptive_ff;

endmodule : backlight_brightness_ctrl_regs

`default_nettype wire

// file: backlight_brightness_ctrl_regs_asserts.sv
/*
 * Port checker for the backlight brightness register bank.
 * Assumes hready_i is tied to hreadyout_o and single word transfers.
 */
`timescale 1ns/1ns
`default_nettype none
module backlight_brightness_ctrl_regs_asserts (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        interface_select_i,
    input wire logic        backlight_output_line_o,
    input wire logic [7:0]  brightness_level_o,
    input wire logic        gamma_eighteen_select_o,
    input wire logic        display_dimming_o,
    input wire logic        brightness_block_on_o,
    input wire logic [1:0]  preservation_mode_o,
    input wire logic        adaptive_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic acc = hsel_i && htrans_i[1] && hready_i;
    wire logic one = haddr_i == 32'h000003A4;
    logic        wr_ff;
    logic [15:0] sh_ff;
    // shadow of control one, follows completed write data phases
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ff <= 1'b0;
            sh_ff <= 16'h0000;
        end else begin
            wr_ff <= acc && hwrite_i && one;
            if (wr_ff) sh_ff <= hwdata_i[15:0];
        end
    end
    property p_target; !sh_ff[3] |=> brightness_level_o == $past(sh_ff[15:8]); endproperty
    a_target: assert property (p_target) else $error("level not target");
    property p_gamma; gamma_eighteen_select_o == sh_ff[6]; endproperty
    a_gamma: assert property (p_gamma) else $error("gamma wrong");
    property p_bl_off; !sh_ff[5] [*3] |-> !backlight_output_line_o; endproperty
    a_bl_off: assert property (p_bl_off) else $error("line on while off");
    property p_dim; display_dimming_o == sh_ff[4]; endproperty
    a_dim: assert property (p_dim) else $error("dimming wrong");
    property p_block; brightness_block_on_o == sh_ff[3]; endproperty
    a_block: assert property (p_block) else $error("block wrong");
    property p_mode; preservation_mode_o == sh_ff[2:1]; endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_adapt; adaptive_active_o |-> $past(sh_ff[0]) && $past(sh_ff[3]); endproperty
    a_adapt: assert property (p_adapt) else $error("adaptive without enable");
    property p_pin; interface_select_i [*4] |-> !adaptive_active_o; endproperty
    a_pin: assert property (p_pin) else $error("adaptive with pin high");
    property p_read;
        acc && !hwrite_i && one |=> !hreadyout_o ##1
            hreadyout_o && hrdata_o == {16'h0000, sh_ff[15:8], 1'b0, sh_ff[6:0]};
    endproperty
    a_read: assert property (p_read) else $error("control one readback wrong");
endmodule : backlight_brightness_ctrl_regs_asserts
bind backlight_brightness_ctrl_regs backlight_brightness_ctrl_regs_asserts u_asserts (.clk_i, .rst_n_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .interface_select_i,
    .backlight_output_line_o, .brightness_level_o, .gamma_eighteen_select_o, .display_dimming_o,
    .brightness_block_on_o, .preservation_mode_o, .adaptive_active_o);
`default_nettype wire

// file: backlight_brightness_ctrl_regs_tb_top.sv
/*
 * Self-checking bench for the backlight brightness register bank.
 * Assumes the checker is bound by its own file; one AHB-Lite master here.
 */
`timescale 1ns/1ns
`default_nettype none
module backlight_brightness_ctrl_regs_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0, clr = 1'b1;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, rd;
    logic [1:0]  htrans = 2'b00, mode;
    logic        hrdy, hresp, line, gam, dim, blk, act;
    logic [7:0]  level;
    logic [15:0] on_cyc;
    int err_count = 0, checks = 0, cyc = 0, m1, m2, t;
    integer seed = 32'hbe44ec86;
    always #50 clk = ~clk;
    backlight_brightness_ctrl_regs u_dut (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .interface_select_i(pin),
        .backlight_output_line_o(line), .brightness_level_o(level), .gamma_eighteen_select_o(gam),
        .display_dimming_o(dim), .brightness_block_on_o(blk), .preservation_mode_o(mode),
        .adaptive_active_o(act));
    backlight_power_model u_far (.clk_i(clk), .line_i(line), .clear_i(clr), .on_cycles_o(on_cyc));
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        rd = hrdata;
        chk("response", 32'h00000000, {31'h0, hresp});
    endtask : xfer
    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk(nm, exp, rd);
    endtask : rdchk
    // applied level the rules demand once an iteration tick has passed
    function automatic int goal();
        int g;
        t = (m1 >> 8) & 255;
        g = ((m1 >> 1) & 3) == 0 ? t : t - (t >> (4 - ((m1 >> 1) & 3)));
        return g < (m2 & 255) ? m2 & 255 : g;
    endfunction : goal
    task automatic measure(input int exp);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        // the count read just after an edge is the one that edge would update
        repeat (257) @(posedge clk);
        chk("on cycles", exp, {16'h0, on_cyc});
    endtask : measure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 32'h3A4; a <= 32'h3B0; a += 4) rdchk("reset value", a, 32'h00000000);
        $display("reset test done");
        repeat (8) begin
            m1 = $random(seed) & 16'hFFFF;
            m2 = $random(seed) & 16'hFFFF;
            pin <= 1'($random(seed));
            xfer(1'b1, 32'h000003A4, m1);
            xfer(1'b1, 32'h000003A8, m2);
            xfer(1'b1, 32'h000003B0, ~m1);
            rdchk("control one", 32'h000003A4, m1 & 16'hFF7F);
            rdchk("control two", 32'h000003A8, m2);
            rdchk("unmapped", 32'h000003B0, 32'h00000000);
            chk("flags", (m1 >> 1) & 8'h2F, {gam, 1'b0, dim, blk, mode});
        end
        $display("register test done");
        pin <= 1'b0;
        t = ($random(seed) & 8'hFE) | 1;
        xfer(1'b1, 32'h000003A8, 32'h00000000);
        xfer(1'b1, 32'h000003A4, (t << 8) | 8'h20);
        repeat (4) @(posedge clk);
        chk("level", t, {24'h0, level});
        measure(t);
        xfer(1'b1, 32'h000003A4, t << 8);
        measure(0);
        rdchk("status", 32'h000003AC, t);
        $display("backlight test done");
        m2 = 8'hA0;
        xfer(1'b1, 32'h000003A8, m2);
        for (int md = 0; md < 4; md++) begin
            m1 = 16'hC829 | (md << 1);
            xfer(1'b1, 32'h000003A4, m1);
            repeat (1100) @(posedge clk);
            chk("adaptive level", goal(), {24'h0, level});
            chk("adaptive", 32'h00000001, {31'h0, act});
        end
        pin <= 1'b1;
        repeat (1100) @(posedge clk);
        chk("pin high level", 8'hC8, {24'h0, level});
        chk("pin high adaptive", 32'h00000000, {31'h0, act});
        pin <= 1'b0;
        xfer(1'b1, 32'h000003A4, m1 | 8'h10);
        repeat (1100) @(posedge clk);
        chk("dimming step", 32'h00000001, {31'h0, (level === 8'hC7) || (level === 8'hC6)});
        $display("brightness test done");
        results();
    end
endmodule : backlight_brightness_ctrl_regs_tb_top
`default_nettype wire

// file: backlight_power_model.sv
/*
 * External backlight supply: counts cycles its PWM input is high.
 * Assumes the bench pulses clear_i before each measurement.
 */
`timescale 1ns/1ns
`default_nettype none
module backlight_power_model (
    input  wire logic        clk_i,
    input  wire logic        line_i,
    input  wire logic        clear_i,
    output logic      [15:0] on_cycles_o
);
    always_ff @(posedge clk_i) begin
        if (clear_i) on_cycles_o <= 16'h0000;
        else if (line_i) on_cycles_o <= on_cycles_o + 16'h0001;
    end
endmodule : backlight_power_model
`default_nettype wire

// file: backlight_pwm_gen.sv
/*
 * Pulse width modulator for the backlight output line.
 * Assumes prescale and duty come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "backlight_brightness_ctrl_consts.svh"

module backlight_pwm_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_i,
    input  wire logic [3:0] prescale_i,
    input  wire logic [7:0] duty_i,
    output logic            pwm_o
);

    logic [`PWM_PRE_W-1:0] pre_cnt_ff;
    logic [7:0]            phase_ff;
    logic                  pwm_ff;
    wire  [`PWM_PRE_W-1:0] pre_limit;
    wire                   step;
    wire                   nxt_pwm;

    // one phase step every 2^prescale cycles, 256 steps per period
    assign pre_limit = (`PWM_PRE_W'(1) << prescale_i) - `PWM_PRE_W'(1);
    assign step      = (pre_cnt_ff >= pre_limit);
    // held low for good while disabled: the external supply sees no pulse
    assign nxt_pwm   = enable_i && (phase_ff < duty_i);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_cnt_ff <= '0;
            phase_ff   <= 8'h00;
            pwm_ff     <= 1'b0;
        end else begin
            pre_cnt_ff <= step ? '0 : pre_cnt_ff + `PWM_PRE_W'(1);
            phase_ff   <= step ? phase_ff + 8'h01 : phase_ff;
            pwm_ff     <= nxt_pwm;
        end
    end

    assign pwm_o = pwm_ff;

endmodule : backlight_pwm_gen

`default_nettype wire
